// >>> inc/vps_pkg.sv
package vps_pkg;

  // ****************************************************************
  // programming word layout
  // ****************************************************************
  localparam int WORD_BITS     = 19;
  localparam int FB_BITS       = 16;
  localparam int SEL_BITS      = 3;
  localparam int SEL_POS       = 16;
  localparam int SWALLOW_BITS  = 4;
  localparam int PROG_BITS     = 12;

  // ****************************************************************
  // reference chain ratios
  // ****************************************************************
  localparam int REF_PRESCALE  = 100;
  localparam int REF_TOTAL_0   = 1600;
  localparam int REF_TOTAL_1   = 800;
  localparam int REF_TOTAL_2   = 400;
  localparam int REF_TOTAL_3   = 200;
  localparam int REF_TOTAL_4   = 2000;
  localparam int REF_TOTAL_5   = 1000;
  localparam int REF_TOTAL_6   = 500;
  localparam int REF_TOTAL_7   = 100;
  localparam int REF_STAGE_W   = 5;
  localparam int REF_PRE_W     = 7;

  // ****************************************************************
  // feedback prescaler moduli and limits
  // ****************************************************************
  localparam int PRESC_LOW     = 15;
  localparam int PRESC_HIGH    = 16;
  localparam int FB_RATIO_MIN  = 240;
  localparam int FB_RATIO_MAX  = 65535;

  // ****************************************************************
  // register map and reset values
  // ****************************************************************
  localparam int          AXI_AW         = 8;
  localparam logic [5:0]  REG_CTRL_IDX   = 6'h00;
  localparam logic [5:0]  REG_STATUS_IDX = 6'h01;
  localparam logic [5:0]  REG_WORD_IDX   = 6'h02;
  localparam int          CTRL_PUMP_EN   = 0;
  localparam logic        CTRL_RESET     = 1'b1;
  localparam int          STAT_LOCK      = 0;
  localparam int          STAT_UP        = 1;
  localparam int          STAT_DN        = 2;
  localparam logic [1:0]  RESP_OKAY      = 2'h0;
  localparam logic [1:0]  RESP_SLVERR    = 2'h2;
  localparam logic [18:0] WORD_RESET     = 19'h0_0000;

endpackage

// >>> rtl/vps_fb_div.sv
`timescale 1ns/100ps
module vps_fb_div
  import vps_pkg::*;
(
  input  wire logic                core_clk_i,
  input  wire logic                rst_i,
  input  wire logic                vco_edge_i,
  input  wire logic                restart_i,
  input  wire logic [FB_BITS-1:0]  ratio_i,
  output logic                     fb_pulse_o
);

  // ****************************************************************
  // dual-modulus divider
  // ****************************************************************
  // ratio = 16*(M+1) - 15-cycles count (16-A); needs M >= 15, i.e. 240
  logic [3:0]           pres_r;
  logic [4:0]           swal_r;
  logic [PROG_BITS-1:0] prog_r;
  logic                 pulse_r;

  wire [PROG_BITS-1:0]    m_val    = ratio_i[FB_BITS-1:SWALLOW_BITS];
  wire [SWALLOW_BITS-1:0] a_val    = ratio_i[SWALLOW_BITS-1:0];
  wire [4:0]              swal_new = 5'(PRESC_HIGH) - {1'b0, a_val};
  wire                    low_mod  = (swal_r != 5'h0_0);
  wire [3:0]              pres_top = low_mod ? 4'(PRESC_LOW - 1)
                                             : 4'(PRESC_HIGH - 1);
  wire                    pres_ev  = vco_edge_i && (pres_r == pres_top);
  wire                    cyc_end  = pres_ev && (prog_r == '0);

  // prescaler and swallow/programmable counters
  always_ff @(posedge core_clk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      pres_r  <= 4'h0;
      swal_r  <= 5'h0_0;
      prog_r  <= '0;
      pulse_r <= 1'b0;
    end
    else if (restart_i)
    begin
      pres_r  <= 4'h0;
      swal_r  <= swal_new;
      prog_r  <= m_val;
      pulse_r <= 1'b0;
    end
    else
    begin
      pulse_r <= cyc_end;
      if (vco_edge_i)
        pres_r <= pres_ev ? 4'h0 : pres_r + 4'h1;
      if (cyc_end)
      begin
        prog_r <= m_val;
        swal_r <= swal_new;
      end
      else if (pres_ev)
      begin
        prog_r <= prog_r - 1'b1;
        if (low_mod)
          swal_r <= swal_r - 5'h0_1;
      end
    end
  end

  assign fb_pulse_o = pulse_r;

endmodule

// >>> rtl/vps_core.sv
// The register offsets and register access over AXI4-Lite were decided locally.
`timescale 1ns/100ps
// Function
// - three-line serial data, clock, load strobe
// - 19-bit word, 3 select then 16 ratio
// - old settings hold until load strobe
// - fixed divide-by-100 then selectable divider
// - select 0xx gives 1600, 800, 400, 200
// - select 1xx gives 2000, 1000, 500, 100
// - open-drain crystal monitor at one hundredth
// - 15/16 prescaler, 4-bit swallow, 12-bit counter
// - feedback ratio equals 16-bit field value
// - feedback ratio must be 240 to 65535
// - phase-frequency comparator, pump up/down, lock
// - open-drain monitors of both divider outputs
// - linear over two pi, repeating beyond
// - beyond one cycle slip one, relock
// - brief glitch on inactive pump allowed
module vps_core
  import vps_pkg::*;
(
  input  wire logic              core_clk_i,
  input  wire logic              rst_i,
  input  wire logic              ref_osc_i,
  input  wire logic              vco_i,
  input  wire logic              ser_data_i,
  input  wire logic              ser_clk_i,
  input  wire logic              ser_load_i,
  input  wire logic              s_axi_awvalid_i,
  output logic                   s_axi_awready_o,
  input  wire logic [AXI_AW-1:0] s_axi_awaddr_i,
  input  wire logic              s_axi_wvalid_i,
  output logic                   s_axi_wready_o,
  input  wire logic [31:0]       s_axi_wdata_i,
  input  wire logic [3:0]        s_axi_wstrb_i,
  output logic                   s_axi_bvalid_o,
  input  wire logic              s_axi_bready_i,
  output logic [1:0]             s_axi_bresp_o,
  input  wire logic              s_axi_arvalid_i,
  output logic                   s_axi_arready_o,
  input  wire logic [AXI_AW-1:0] s_axi_araddr_i,
  output logic                   s_axi_rvalid_o,
  input  wire logic              s_axi_rready_i,
  output logic [31:0]            s_axi_rdata_o,
  output logic [1:0]             s_axi_rresp_o,
  output logic                   xtal_mon_oe_o,
  output logic                   ref_div_monitor_out_oe_o,
  output logic                   fb_div_mon_oe_o,
  output logic                   pump_up_oe_o,
  output logic                   pump_down_out_oe_o,
  output logic                   lock_indicate_n_oe_o
);

  // ****************************************************************
  // helper functions
  // ****************************************************************
  // stage count after the fixed prescaler for a select code
  function automatic logic [REF_STAGE_W-1:0] ref_stage(
    input logic [SEL_BITS-1:0] sel);
    int tot;
    begin
      case (sel)
        3'h0:    tot = REF_TOTAL_0;
        3'h1:    tot = REF_TOTAL_1;
        3'h2:    tot = REF_TOTAL_2;
        3'h3:    tot = REF_TOTAL_3;
        3'h4:    tot = REF_TOTAL_4;
        3'h5:    tot = REF_TOTAL_5;
        3'h6:    tot = REF_TOTAL_6;
        default: tot = REF_TOTAL_7;
      endcase
      ref_stage = REF_STAGE_W'(tot / REF_PRESCALE);
    end
  endfunction

  // ****************************************************************
  // pin synchronisers
  // ****************************************************************
  // every pin is foreign to core_clk; three stages, third for edges
  logic [4:0] sync1_r;
  logic [4:0] sync2_r;
  logic [4:0] sync3_r;

  always_ff @(posedge core_clk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      sync1_r <= 5'h00;
      sync2_r <= 5'h00;
      sync3_r <= 5'h00;
    end
    else
    begin
      sync1_r <= {ser_load_i, ser_clk_i, ser_data_i, vco_i, ref_osc_i};
      sync2_r <= sync1_r;
      sync3_r <= sync2_r;
    end
  end

  // rising edges seen after the second stage only
  wire ref_edge  = sync2_r[0] && !sync3_r[0];
  wire vco_edge  = sync2_r[1] && !sync3_r[1];
  wire ser_dat   = sync2_r[2];
  wire sclk_edge = sync2_r[3] && !sync3_r[3];
  wire load_edge = sync2_r[4] && !sync3_r[4];

  // ****************************************************************
  // serial word input
  // ****************************************************************
  logic [WORD_BITS-1:0] shift_r;
  logic [WORD_BITS-1:0] word_r;
  logic                 commit_r;

  // shift on clock, commit on strobe
  always_ff @(posedge core_clk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      shift_r  <= WORD_RESET;
      word_r   <= WORD_RESET;
      commit_r <= 1'b0;
    end
    else
    begin
      // first bit ends up at the top
      if (sclk_edge)
        shift_r <= {shift_r[WORD_BITS-2:0], ser_dat};
      if (load_edge)
        word_r <= shift_r;
      commit_r <= load_edge;
    end
  end

  wire [SEL_BITS-1:0] ref_sel  = word_r[SEL_POS +: SEL_BITS];
  wire [FB_BITS-1:0]  fb_ratio = word_r[FB_BITS-1:0];

  // ****************************************************************
  // reference chain
  // ****************************************************************
  logic [REF_PRE_W-1:0]   pre_cnt_r;
  logic [REF_STAGE_W-1:0] stg_cnt_r;
  logic                   xtal_tog_r;
  logic                   ref_pulse_r;

  wire pre_half = ref_edge && (pre_cnt_r == REF_PRE_W'(REF_PRESCALE/2 - 1));
  wire pre_end  = ref_edge && (pre_cnt_r == REF_PRE_W'(REF_PRESCALE - 1));
  wire stg_end  = pre_end && (stg_cnt_r == ref_stage(ref_sel) - 1'b1);

  always_ff @(posedge core_clk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      pre_cnt_r   <= '0;
      stg_cnt_r   <= '0;
      xtal_tog_r  <= 1'b0;
      ref_pulse_r <= 1'b0;
    end
    else
    begin
      if (pre_half || pre_end)
        xtal_tog_r <= !xtal_tog_r;
      if (pre_end)
        pre_cnt_r <= '0;
      else if (ref_edge)
        pre_cnt_r <= pre_cnt_r + 1'b1;
      if (commit_r || stg_end)
        stg_cnt_r <= '0;
      else if (pre_end)
        stg_cnt_r <= stg_cnt_r + 1'b1;
      ref_pulse_r <= stg_end && !commit_r;
    end
  end

  // ****************************************************************
  // feedback chain
  // ****************************************************************
  logic fb_pulse;

  vps_fb_div u_fb_div
  (
    .core_clk_i (core_clk_i),
    .rst_i      (rst_i),
    .vco_edge_i (vco_edge),
    .restart_i  (commit_r),
    .ratio_i    (fb_ratio),
    .fb_pulse_o (fb_pulse)
  );

  // ****************************************************************
  // phase-frequency comparator
  // ****************************************************************
  logic ctrl_en_r;
  logic up_r;
  logic dn_r;
  logic up_oe_r;
  logic dn_oe_r;
  logic lock_r;
  logic ref_mon_r;
  logic fb_mon_r;

  wire up_set = up_r || ref_pulse_r;
  wire dn_set = dn_r || fb_pulse;
  wire both   = up_set && dn_set;
  wire up_nxt = up_set && !both;
  wire dn_nxt = dn_set && !both;

  always_ff @(posedge core_clk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      up_r      <= 1'b0;
      dn_r      <= 1'b0;
      up_oe_r   <= 1'b0;
      dn_oe_r   <= 1'b0;
      lock_r    <= 1'b0;
      ref_mon_r <= 1'b0;
      fb_mon_r  <= 1'b0;
    end
    else
    begin
      up_r    <= up_nxt;
      dn_r    <= dn_nxt;
      // coincident edges clear both, no overlap pulse
      up_oe_r <= up_nxt && ctrl_en_r;
      dn_oe_r <= dn_nxt && ctrl_en_r;
      lock_r  <= !(up_nxt || dn_nxt);
      if (ref_pulse_r)
        ref_mon_r <= !ref_mon_r;
      if (fb_pulse)
        fb_mon_r <= !fb_mon_r;
    end
  end

  // ****************************************************************
  // axi4-lite register slave
  // ****************************************************************
  logic              awready_r;
  logic              wready_r;
  logic              aw_held_r;
  logic              w_held_r;
  logic [5:0]        aw_idx_r;
  logic              wr_en_r;
  logic              wr_bit_r;
  logic              bvalid_r;
  logic [1:0]        bresp_r;
  logic              arready_r;
  logic              rvalid_r;
  logic [31:0]       rdata_r;
  logic [1:0]        rresp_r;

  wire aw_hs   = s_axi_awvalid_i && awready_r;
  wire w_hs    = s_axi_wvalid_i && wready_r;
  wire do_wr   = aw_held_r && w_held_r && !bvalid_r;
  wire wr_ok   = (aw_idx_r == REG_CTRL_IDX);
  wire ar_hs   = s_axi_arvalid_i && arready_r;
  wire [5:0] ar_idx = s_axi_araddr_i[AXI_AW-1:2];
  wire [31:0] status_w = {29'h0, dn_r, up_r, lock_r};
  wire rd_hit  = (ar_idx == REG_CTRL_IDX) || (ar_idx == REG_STATUS_IDX)
               || (ar_idx == REG_WORD_IDX);
  wire [31:0] rd_mux =
      (ar_idx == REG_CTRL_IDX)   ? {31'h0, ctrl_en_r} :
      (ar_idx == REG_STATUS_IDX) ? status_w :
      (ar_idx == REG_WORD_IDX)   ? {13'h0, word_r} : 32'h0000_0000;

  // write path: address and data in either order
  always_ff @(posedge core_clk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      awready_r <= 1'b0;
      wready_r  <= 1'b0;
      aw_held_r <= 1'b0;
      w_held_r  <= 1'b0;
      aw_idx_r  <= 6'h00;
      wr_en_r   <= 1'b0;
      wr_bit_r  <= 1'b0;
      bvalid_r  <= 1'b0;
      bresp_r   <= RESP_OKAY;
      ctrl_en_r <= CTRL_RESET;
    end
    else
    begin
      if (aw_hs)
        awready_r <= 1'b0;
      else if (!aw_held_r && !bvalid_r)
        awready_r <= 1'b1;
      if (w_hs)
        wready_r <= 1'b0;
      else if (!w_held_r && !bvalid_r)
        wready_r <= 1'b1;
      if (aw_hs)
      begin
        aw_held_r <= 1'b1;
        aw_idx_r  <= s_axi_awaddr_i[AXI_AW-1:2];
      end
      if (w_hs)
      begin
        w_held_r <= 1'b1;
        wr_en_r  <= s_axi_wstrb_i[0];
        wr_bit_r <= s_axi_wdata_i[CTRL_PUMP_EN];
      end
      // pump enable only gates outputs; comparator keeps running
      if (do_wr)
      begin
        aw_held_r <= 1'b0;
        w_held_r  <= 1'b0;
        bvalid_r  <= 1'b1;
        bresp_r   <= wr_ok ? RESP_OKAY : RESP_SLVERR;
        if (wr_ok && wr_en_r)
          ctrl_en_r <= wr_bit_r;
      end
      else if (bvalid_r && s_axi_bready_i)
        bvalid_r <= 1'b0;
    end
  end

  // read path: answer one cycle after the address is taken
  always_ff @(posedge core_clk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      arready_r <= 1'b0;
      rvalid_r  <= 1'b0;
      rdata_r   <= 32'h0000_0000;
      rresp_r   <= RESP_OKAY;
    end
    else
    begin
      if (ar_hs)
      begin
        arready_r <= 1'b0;
        rvalid_r  <= 1'b1;
        rdata_r   <= rd_mux;
        rresp_r   <= rd_hit ? RESP_OKAY : RESP_SLVERR;
      end
      else if (rvalid_r && s_axi_rready_i)
        rvalid_r <= 1'b0;
      else if (!rvalid_r)
        arready_r <= 1'b1;
    end
  end

  // ****************************************************************
  // outputs
  // ****************************************************************
  assign s_axi_awready_o          = awready_r;
  assign s_axi_wready_o           = wready_r;
  assign s_axi_bvalid_o           = bvalid_r;
  assign s_axi_bresp_o            = bresp_r;
  assign s_axi_arready_o          = arready_r;
  assign s_axi_rvalid_o           = rvalid_r;
  assign s_axi_rdata_o            = rdata_r;
  assign s_axi_rresp_o            = rresp_r;
  assign xtal_mon_oe_o            = xtal_tog_r;
  assign ref_div_monitor_out_oe_o = ref_mon_r;
  assign fb_div_mon_oe_o          = fb_mon_r;
  assign pump_up_oe_o             = up_oe_r;
  assign pump_down_out_oe_o       = dn_oe_r;
  assign lock_indicate_n_oe_o     = lock_r;

endmodule

// >>> verif/vps_chk_assertions.sv
`timescale 1ns/100ps
// ************************************************
// port checks for the synthesiser core
// ************************************************
module vps_chk
  import vps_pkg::*;
(
  input wire logic              core_clk_i,
  input wire logic              rst_i,
  input wire logic              s_axi_awvalid_i,
  input wire logic              s_axi_awready_o,
  input wire logic [AXI_AW-1:0] s_axi_awaddr_i,
  input wire logic              s_axi_wvalid_i,
  input wire logic              s_axi_wready_o,
  input wire logic              s_axi_bvalid_o,
  input wire logic [1:0]        s_axi_bresp_o,
  input wire logic              s_axi_arvalid_i,
  input wire logic              s_axi_arready_o,
  input wire logic [AXI_AW-1:0] s_axi_araddr_i,
  input wire logic              s_axi_rvalid_o,
  input wire logic [31:0]       s_axi_rdata_o,
  input wire logic [1:0]        s_axi_rresp_o,
  input wire logic              xtal_mon_oe_o,
  input wire logic              ref_div_monitor_out_oe_o,
  input wire logic              pump_up_oe_o,
  input wire logic              pump_down_out_oe_o,
  input wire logic              lock_indicate_n_oe_o
);
  localparam logic [7:0] CTRL_A = {REG_CTRL_IDX, 2'b00};
  localparam logic [7:0] STAT_A = {REG_STATUS_IDX, 2'b00};
  localparam logic [7:0] WORD_A = {REG_WORD_IDX, 2'b00};

  // handshake decodes; only the control word accepts writes
  wire logic aw_go  = s_axi_awvalid_i && s_axi_awready_o
                      && s_axi_wvalid_i && s_axi_wready_o;
  wire logic ar_go  = s_axi_arvalid_i && s_axi_arready_o;
  wire logic ar_bad = !(s_axi_araddr_i inside {CTRL_A, STAT_A, WORD_A});
  wire logic pumping = pump_up_oe_o || pump_down_out_oe_o;

  default clocking cb @(posedge core_clk_i);
  endclocking
  default disable iff (rst_i);

  a_pumps_apart:
    assert property (!(pump_up_oe_o && pump_down_out_oe_o))
    else $error("both pump outputs driven");
  a_lock_drops:
    assert property (pumping [*3] |-> !lock_indicate_n_oe_o)
    else $error("lock shown during correction");
  // monitor half period is fifty ref edges
  a_xtal_steady:
    assert property ($changed(xtal_mon_oe_o) |=> $stable(xtal_mon_oe_o)[*8])
    else $error("crystal monitor toggles too fast");
  // no ratio below one hundred ref edges
  a_refmon_steady:
    assert property ($changed(ref_div_monitor_out_oe_o)
      |=> $stable(ref_div_monitor_out_oe_o)[*8])
    else $error("reference monitor toggles too fast");
  // any read handshake answered with rvalid next cycle
  a_read_answers:
    assert property (ar_go |=> s_axi_rvalid_o)
    else $error("read answer late");
  // unmapped read answers error with zero
  a_read_unmapped:
    assert property (ar_go && ar_bad |=> s_axi_rresp_o == RESP_SLVERR
      && s_axi_rdata_o == 32'h0000_0000)
    else $error("unmapped read not refused");
  // word changes only by the load strobe
  a_write_refused:
    // held address and data meet one edge later, bvalid the next
    assert property (aw_go && s_axi_awaddr_i != CTRL_A
      |=> ##1 (s_axi_bvalid_o && s_axi_bresp_o == RESP_SLVERR))
    else $error("write to fixed place accepted");
  // no new write taken while answering
  a_busy_refuse:
    assert property (s_axi_bvalid_o |-> !s_axi_awready_o && !s_axi_wready_o)
    else $error("write taken while response pending");

  c_pump_up: cover property (pump_up_oe_o);
  c_pump_dn: cover property (pump_down_out_oe_o);
  c_bad_read: cover property (ar_go && ar_bad);
endmodule

bind vps_core vps_chk u_chk (.*);

// >>> verif/vps_host.sv
`timescale 1ns/100ps
// ************************************************
// host end of the three-wire programming link
// ************************************************
module vps_host
(
  input  wire logic clk_i,
  output logic      ser_data_o,
  output logic      ser_clk_o,
  output logic      ser_load_o
);
  // idle: shift clock and load low
  initial
  begin
    ser_data_o = 1'b0;
    ser_clk_o  = 1'b0;
    ser_load_o = 1'b0;
  end

  // nineteen bits msb first, select bits lead
  // data settles g cycles before the rising clock
  task automatic send(input logic [18:0] w, input logic commit,
                      input int g);
    for (int i = 18; i >= 0; i--)
    begin
      @(posedge clk_i);
      ser_data_o <= w[i];
      repeat (g) @(posedge clk_i);
      ser_clk_o <= 1'b1;
      repeat (g) @(posedge clk_i);
      ser_clk_o <= 1'b0;
    end
    // stale bit is inverted so it cannot pass as valid
    @(posedge clk_i);
    ser_data_o <= ~w[0];
    // one pulse commits the whole word
    if (commit)
    begin
      ser_load_o <= 1'b1;
      repeat (5) @(posedge clk_i);
      ser_load_o <= 1'b0;
    end
    repeat (8) @(posedge clk_i);
  endtask
endmodule

// >>> verif/vps_core_tb.sv
`timescale 1ns/100ps
module vps_core_tb
  import vps_pkg::*;
;
  // ************************************************
  // pins, model state and counters
  // ************************************************
  localparam logic [7:0] CTRL_A = {REG_CTRL_IDX, 2'b00};
  localparam logic [7:0] STAT_A = {REG_STATUS_IDX, 2'b00};
  localparam logic [7:0] WORD_A = {REG_WORD_IDX, 2'b00};
  int ref_tab [8] = '{REF_TOTAL_0, REF_TOTAL_1, REF_TOTAL_2, REF_TOTAL_3,
                      REF_TOTAL_4, REF_TOTAL_5, REF_TOTAL_6, REF_TOTAL_7};
  int                failures = 0;
  int                tests_run = 0;
  int                ref_n = 0;
  int                vco_n = 0;
  logic              ref_run = 1'b0;
  logic              vco_run = 1'b0;
  logic              ctrl_m = CTRL_RESET;
  logic [18:0]       word_m = WORD_RESET;
  logic              core_clk_i = 1'b0;
  logic              rst_i = 1'b1;
  logic              ref_osc_i = 1'b0;
  logic              vco_i = 1'b0;
  logic              ser_data_i, ser_clk_i, ser_load_i;
  logic              s_axi_awvalid_i = 1'b0, s_axi_wvalid_i = 1'b0;
  logic              s_axi_bready_i = 1'b0, s_axi_arvalid_i = 1'b0;
  logic              s_axi_rready_i = 1'b0;
  logic [AXI_AW-1:0] s_axi_awaddr_i = 8'h00, s_axi_araddr_i = 8'h00;
  logic [31:0]       s_axi_wdata_i = 32'h0000_0000;
  logic [3:0]        s_axi_wstrb_i = 4'hf;
  logic              s_axi_awready_o, s_axi_wready_o, s_axi_bvalid_o;
  logic              s_axi_arready_o, s_axi_rvalid_o;
  logic [1:0]        s_axi_bresp_o, s_axi_rresp_o;
  logic [31:0]       s_axi_rdata_o;
  logic              xtal_mon_oe_o, ref_div_monitor_out_oe_o;
  logic              fb_div_mon_oe_o, pump_up_oe_o, pump_down_out_oe_o;
  logic              lock_indicate_n_oe_o;

  always #50 core_clk_i = ~core_clk_i;

  // pin stimulus: one rising edge every two cycles, edges counted
  always @(posedge core_clk_i)
  begin
    ref_osc_i <= ref_run & ~ref_osc_i;
    vco_i     <= vco_run & ~vco_i;
    if (ref_run && !ref_osc_i) ref_n <= ref_n + 1;
    if (vco_run && !vco_i) vco_n <= vco_n + 1;
  end

  vps_core u_dut (.*);
  vps_host u_host (.clk_i(core_clk_i), .ser_data_o(ser_data_i),
                   .ser_clk_o(ser_clk_i), .ser_load_o(ser_load_i));

  // ************************************************
  // shared tasks
  // ************************************************
  task automatic chk(input string nm, input logic [31:0] got, exp);
    tests_run++;
    if (got !== exp)
    begin
      failures++;
      $display("[ERR] %s expected %h seen %h", nm, exp, got);
    end
  endtask

  task automatic tally_and_finish;
    $display("comparisons %0d mismatches %0d", tests_run, failures);
    if (failures == 0 && tests_run > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask

  function automatic logic mon(input int s);
    case (s)
      0: return ref_div_monitor_out_oe_o;
      1: return fb_div_mon_oe_o;
      2: return xtal_mon_oe_o;
      3: return pump_up_oe_o;
      default: return pump_down_out_oe_o;
    endcase
  endfunction

  // edges between two toggles; first toggle skipped as restart is partial
  task automatic span(input int s, output int n);
    logic v;
    int   e0;
    for (int k = 0; k < 2; k++)
    begin
      v = mon(s);
      e0 = s == 1 ? vco_n : ref_n;
      do @(negedge core_clk_i); while (mon(s) === v);
    end
    n = (s == 1 ? vco_n : ref_n) - e0;
  endtask

  task automatic watch(input int s, input int cyc, output logic seen);
    seen = 1'b0;
    repeat (cyc) @(negedge core_clk_i) seen |= mon(s);
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [1:0] e;
    e = a == CTRL_A ? RESP_OKAY : RESP_SLVERR;
    @(posedge core_clk_i);
    s_axi_awaddr_i <= a;
    s_axi_awvalid_i <= 1'b1;
    s_axi_wdata_i <= d;
    s_axi_wvalid_i <= 1'b1;
    s_axi_bready_i <= 1'b1;
    fork
      begin
        do @(posedge core_clk_i); while (!s_axi_awready_o);
        s_axi_awvalid_i <= 1'b0;
      end
      begin
        do @(posedge core_clk_i); while (!s_axi_wready_o);
        s_axi_wvalid_i <= 1'b0;
      end
    join
    while (!s_axi_bvalid_o) @(posedge core_clk_i);
    s_axi_bready_i <= 1'b0;
    chk("bresp", s_axi_bresp_o, e);
    if (e == RESP_OKAY)
      ctrl_m = d[0];
  endtask

  task automatic rd(input logic [7:0] a);
    logic [1:0]  e;
    logic [31:0] x;
    e = (a inside {CTRL_A, STAT_A, WORD_A}) ? RESP_OKAY : RESP_SLVERR;
    // status is only read while idle: locked, no pump pulse pending
    x = a == CTRL_A ? 32'(ctrl_m) : a == WORD_A ? 32'(word_m)
      : a == STAT_A ? 32'h0000_0001 : 32'h0000_0000;
    @(posedge core_clk_i);
    s_axi_araddr_i <= a;
    s_axi_arvalid_i <= 1'b1;
    s_axi_rready_i <= 1'b1;
    do @(posedge core_clk_i); while (!s_axi_arready_o);
    s_axi_arvalid_i <= 1'b0;
    while (!s_axi_rvalid_o) @(posedge core_clk_i);
    s_axi_rready_i <= 1'b0;
    chk("rresp", s_axi_rresp_o, e);
    chk("rdata", s_axi_rdata_o, x);
  endtask

  task automatic load(input logic [18:0] w, input logic commit,
                      input int g);
    u_host.send(w, commit, g);
    if (commit)
      word_m = w;
    rd(WORD_A);
  endtask

  // ************************************************
  // main sequence and watchdog
  // ************************************************
  initial
  begin
    int          n;
    logic        seen;
    logic [15:0] r;
    logic [7:0]  adr [5];
    adr = '{CTRL_A, STAT_A, WORD_A, 8'h0c, 8'hfc};
    void'($urandom(32'h7ed1));
    repeat (5) @(posedge core_clk_i);
    rst_i <= 1'b0;
    repeat (3) @(negedge core_clk_i);
    chk("lock", lock_indicate_n_oe_o, 1'b1);
    chk("pumps", {pump_up_oe_o, pump_down_out_oe_o}, 2'b00);
    foreach (adr[i])
    begin
      rd(adr[i]);
      wr(adr[i], $urandom);
      rd(adr[i]);
    end
    $display("test registers done");
    ref_run = 1'b1;
    vco_run = 1'b1;
    for (int s = 0; s < 8; s++)
    begin
      load({3'(s), 16'(FB_RATIO_MIN)}, 1'b1, 2);
      span(0, n);
      chk("ref ratio", n, ref_tab[s]);
    end
    // shifting alone, slow host, old ratio keeps running
    // shifted select differs from the committed one, so a leak shows
    load(19'h0_ffff, 1'b0, 6);
    span(0, n);
    chk("held ratio", n, ref_tab[7]);
    span(2, n);
    chk("xtal half period", n, REF_PRESCALE / 2);
    $display("test reference chain done");
    // low limit, swallow boundary, random ratio
    for (int k = 0; k < 3; k++)
    begin
      r = k == 0 ? 16'(FB_RATIO_MIN) : k == 1 ? 16'h0100
        : 16'd241 + 16'($urandom % 700);
      load({3'b111, r}, 1'b1, 2);
      span(1, n);
      chk("fb ratio", n, r);
    end
    $display("test feedback chain done");
    // ref alone leaves up pending, vco alone gives down
    load({3'b111, 16'(FB_RATIO_MIN)}, 1'b1, 2);
    vco_run = 1'b0;
    wr(CTRL_A, 32'h0000_0000);
    watch(3, 600, seen);
    chk("up gated", seen, 1'b0);
    wr(CTRL_A, 32'h0000_0001);
    watch(3, 600, seen);
    chk("up seen", seen, 1'b1);
    chk("unlocked", lock_indicate_n_oe_o, 1'b0);
    ref_run = 1'b0;
    vco_run = 1'b1;
    watch(4, 1200, seen);
    chk("down seen", seen, 1'b1);
    $display("test comparator done");
    tally_and_finish();
  end

  initial
  begin
    repeat (80000) @(posedge core_clk_i);
    failures++;
    tally_and_finish();
  end
endmodule
